// *** shared/frame_out_pkg.sv ***
/*
  Constants for the two-wire frame output: timing, frame layout,
  sync word field positions, checksum settings.
  Assumes a 100 MHz system clock and a host-driven serial clock.
*/
package frame_out_pkg;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          WD_TIMEOUT_NS  = 3600;
  localparam int          WD_CYCLES_INT  = WD_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int          WD_CNT_W       = 9;
  localparam logic [8:0]  WD_CYCLES      = WD_CNT_W'(WD_CYCLES_INT);
  localparam int          PIN_COUNT      = 6;
  localparam int          FRAME_W        = 80;
  localparam int          SAMPLE_W       = 24;
  localparam int          CRC_W          = 16;
  localparam logic [6:0]  FRAME_BITS_64  = 7'h40;
  localparam logic [6:0]  FRAME_BITS_HI  = 7'h50;
  localparam logic [6:0]  PAYLOAD_64     = 7'h30;
  localparam logic [6:0]  PAYLOAD_HI     = 7'h40;
  localparam logic [15:0] CRC_POLY       = 16'h8005;
  localparam logic [15:0] CRC_INIT       = 16'h0000;
  localparam logic [7:0]  SYNC_CONST     = 8'ha5;
  // settings byte positions, constant byte sits below it
  localparam int          POS_CNT_MSB    = 7;
  localparam int          POS_CNT_LSB    = 6;
  localparam int          POS_OSR_MSB    = 5;
  localparam int          POS_OSR_LSB    = 4;
  localparam int          POS_BOOST      = 3;
  localparam int          POS_GAIN_MSB   = 2;
  localparam int          POS_GAIN_LSB   = 1;
  localparam logic [1:0]  OSR_64         = 2'h0;
  localparam logic [1:0]  LAST_FRAME     = 2'h3;
  localparam logic [11:0] CONV_BASE      = 12'h100;
  localparam logic [11:0] START_BASE     = 12'h080;
  localparam logic [1:0]  SETTLE_LAST    = 2'h2;
  typedef enum logic [1:0] {CONV_OFF, CONV_START, CONV_SETTLE, CONV_RUN}
    conv_e;
endpackage

// *** shared/clock_watch_if.sv ***
/*
  Carrier between the serial clock watcher and the frame core.
  Assumes both ends run on the system clock.
*/
interface clock_watch_if;
  logic sck_rise;
  logic sck_fall;
  logic wd_fire;
  modport source (output sck_rise, output sck_fall, output wd_fire);
  modport sink   (input sck_rise, input sck_fall, input wd_fire);
endinterface

// *** rtl/sck_watchdog.sv ***
/*
  Samples the host serial clock, finds its edges and runs the
  high-phase watchdog.
  Assumes the serial clock is far slower than the system clock.
*/
module sck_watchdog
  import frame_out_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire logic        sck_in,
  clock_watch_if.source    lk
);
  logic                sck_meta_r;
  logic                sck_sync_r;
  logic                sck_prev_r;
  logic                armed_r;
  logic [WD_CNT_W-1:0] wd_cnt_r;
  logic                rise_r;
  logic                fall_r;
  logic                fire_r;

  wire rise_now = sck_sync_r & ~sck_prev_r;
  wire fall_now = ~sck_sync_r & sck_prev_r;
  wire wd_hit   = armed_r & sck_sync_r & (wd_cnt_r == WD_CYCLES - 9'h001);

  always_ff @(posedge clk_sys_in)
  begin
    sck_meta_r <= sck_in;
    sck_sync_r <= sck_meta_r;
  end

  // edges only, so any duty cycle within timing is fine
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      sck_prev_r <= 1'b0;
      rise_r     <= 1'b0;
      fall_r     <= 1'b0;
    end
    else
    begin
      sck_prev_r <= sck_sync_r;
      rise_r     <= rise_now;
      fall_r     <= fall_now;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in | ~sck_sync_r)
    begin
      armed_r  <= 1'b0; // low phase clears, never fires
      wd_cnt_r <= '0;
    end
    else if (rise_now)
    begin
      armed_r  <= 1'b1; // timer starts on rising edge
      wd_cnt_r <= 9'h001;
    end
    else if (armed_r)
    begin
      armed_r  <= ~wd_hit;
      wd_cnt_r <= wd_cnt_r + 9'h001;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      fire_r <= 1'b0;
    else
      fire_r <= wd_hit;
  end

  // check helper: length of the current high phase, saturating,
  // kept apart from the armed logic so a broken arm still shows
  logic [WD_CNT_W-1:0] high_len_r;
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in | ~sck_sync_r)
      high_len_r <= '0;
    else if (high_len_r != '1)
      high_len_r <= high_len_r + 9'h001;
  end

  assign lk.sck_rise = rise_r;
  assign lk.sck_fall = fall_r;
  assign lk.wd_fire  = fire_r;

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  chk_watchdog_fire: assert property (
    (sck_sync_r && high_len_r == WD_CYCLES - 9'h001) |=> fire_r)
    else $error("watchdog did not fire on long high phase");
  chk_low_no_fire: assert property (
    (!sck_sync_r && !sck_prev_r) |=> !fire_r)
    else $error("watchdog fired while clock low");
  cov_watchdog: cover property (fire_r);
endmodule

// *** rtl/two_wire_framer.sv ***
/*
  Two-wire frame output: strap latching, conversion timing,
  four-frame sets on the serial output, watchdog reset.
  Assumes samples come from the converter on the system clock and
  the host drives the serial clock.
*/
module two_wire_framer
  import frame_out_pkg::*;
(
  input  wire logic                clk_sys_in,
  input  wire logic                sys_rst_in,
  input  wire logic                sck_in,
  input  wire logic                interface_select_pin_in,
  input  wire logic                oversampling_select_lsb_in,
  input  wire logic                oversampling_select_msb_in,
  input  wire logic                boost_select_in,
  input  wire logic                ch0_gain_select_lsb_in,
  input  wire logic                ch0_gain_select_msb_in,
  input  wire logic [frame_out_pkg::SAMPLE_W-1:0] channel0_sample_in,
  input  wire logic [frame_out_pkg::SAMPLE_W-1:0] channel1_sample_in,
  output logic                     sdo_out,
  output logic                     two_wire_active_out,
  output logic [1:0]               osr_select_out,
  output logic [1:0]               ch0_gain_select_out,
  output logic                     boost_select_out,
  output logic                     converter_reset_out,
  output logic                     result_ready_out
);
  import frame_out_pkg::*;

  clock_watch_if lk ();

  sck_watchdog u_watch (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .sck_in     (sck_in),
    .lk         (lk)
  );

  // full reset to defaults on watchdog expiry
  wire core_rst = sys_rst_in | lk.wd_fire;

  wire [PIN_COUNT-1:0] pins_raw = {interface_select_pin_in,
    ch0_gain_select_msb_in, ch0_gain_select_lsb_in, boost_select_in,
    oversampling_select_msb_in, oversampling_select_lsb_in};
  wire [PIN_COUNT-1:0] pins_sync;

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++)
    begin : g_pin
      logic meta_r;
      logic sync_r;
      always_ff @(posedge clk_sys_in)
      begin
        meta_r <= pins_raw[g];
        sync_r <= meta_r;
      end
      assign pins_sync[g] = sync_r;
    end
  endgenerate

  logic       mode_prev_r;
  logic       two_wire_r;
  logic [4:0] straps_r;
  wire        mode_rise = pins_sync[5] & ~mode_prev_r;

  // prev cleared by reset, so a pin held high relatches on exit
  always_ff @(posedge clk_sys_in)
  begin
    if (core_rst)
    begin
      mode_prev_r <= 1'b0;
      two_wire_r  <= 1'b0;
      straps_r    <= '0;
    end
    else
    begin
      mode_prev_r <= pins_sync[5];
      if (mode_rise)
      begin
        two_wire_r <= 1'b1;
        straps_r   <= pins_sync[4:0];
      end
    end
  end

  wire [1:0]  osr_sel  = straps_r[1:0];
  wire [1:0]  gain_sel = straps_r[4:3];
  wire        boost    = straps_r[2];
  wire        osr64    = (osr_sel == OSR_64);
  wire [11:0] conv_len = CONV_BASE << osr_sel;  // 4 x ratio
  wire [11:0] half_len = START_BASE << osr_sel; // 2 x ratio

  conv_e      conv_st_r;
  logic [11:0] conv_cnt_r;
  logic [1:0] settle_cnt_r;
  wire        rise      = lk.sck_rise;
  wire        fall      = lk.sck_fall;
  wire        conv_wrap = conv_cnt_r == conv_len - 12'h001;
  wire        start_end = conv_cnt_r == half_len - 12'h001;
  wire        settled   = settle_cnt_r == SETTLE_LAST;
  wire        ready     = rise & conv_wrap &
    ((conv_st_r == CONV_RUN) | ((conv_st_r == CONV_SETTLE) & settled));

  always_ff @(posedge clk_sys_in)
  begin
    if (core_rst)
    begin
      conv_st_r    <= CONV_OFF;
      conv_cnt_r   <= '0;
      settle_cnt_r <= '0;
    end
    else
    begin
      case (conv_st_r)
        CONV_OFF:
          if (two_wire_r)
            conv_st_r <= CONV_START;
        CONV_START:
          if (rise)
          begin
            conv_cnt_r <= start_end ? 12'h000 : conv_cnt_r + 12'h001;
            if (start_end)
              conv_st_r <= CONV_SETTLE;
          end
        CONV_SETTLE, CONV_RUN:
          if (rise)
          begin
            conv_cnt_r <= conv_wrap ? 12'h000 : conv_cnt_r + 12'h001;
            if (conv_wrap && conv_st_r == CONV_SETTLE)
            begin
              settle_cnt_r <= settle_cnt_r + 2'h1;
              if (settled)
                conv_st_r <= CONV_RUN;
            end
          end
        default:
          conv_st_r <= CONV_OFF;
      endcase
    end
  end

  logic [SAMPLE_W-1:0] ch0_r;
  logic [SAMPLE_W-1:0] ch1_r;
  logic [FRAME_W-1:0]  shreg_r;
  logic [CRC_W-1:0]    crc_r;
  logic [6:0]          bit_cnt_r;
  logic [1:0]          frame_r;
  logic                active_r;
  logic                sdo_r;
  logic                ready_r;
  logic                conv_rst_r;

  function automatic logic [FRAME_W-1:0] build_frame(
    input logic [1:0]          cnt,
    input logic [SAMPLE_W-1:0] c0,
    input logic [SAMPLE_W-1:0] c1);
    logic [7:0] set_b;
    set_b               = 8'h00;
    set_b[POS_CNT_MSB]  = cnt[1];
    set_b[POS_CNT_LSB]  = cnt[0];
    set_b[POS_OSR_MSB]  = osr_sel[1];
    set_b[POS_OSR_LSB]  = osr_sel[0];
    set_b[POS_BOOST]    = boost;
    set_b[POS_GAIN_MSB] = gain_sel[1];
    set_b[POS_GAIN_LSB] = gain_sel[0];
    if (osr64)
      build_frame = {set_b, SYNC_CONST, c0[23:8], c1[23:8], 32'h0};
    else
      build_frame = {set_b, SYNC_CONST, c0, c1, 16'h0};
  endfunction

  wire       out_bit     = shreg_r[FRAME_W-1]; // msb first
  wire [15:0] crc_shift  = {crc_r[14:0], 1'b0};
  wire [15:0] crc_nxt    = (crc_r[15] ^ out_bit) ? crc_shift ^ CRC_POLY
                                                 : crc_shift;
  wire [6:0] payload_len = osr64 ? PAYLOAD_64 : PAYLOAD_HI;
  wire [6:0] frame_len   = osr64 ? FRAME_BITS_64 : FRAME_BITS_HI;
  wire       in_payload  = bit_cnt_r < payload_len;
  wire       payload_end = bit_cnt_r == payload_len - 7'h01;
  wire       frame_end   = bit_cnt_r == frame_len - 7'h01;
  wire       set_end     = frame_end & (frame_r == LAST_FRAME);
  wire [1:0] frame_next  = frame_r + 2'h1;

  always_ff @(posedge clk_sys_in)
  begin
    if (core_rst)
    begin
      active_r  <= 1'b0;
      sdo_r     <= 1'b0;
      shreg_r   <= '0;
      crc_r     <= CRC_INIT;
      bit_cnt_r <= '0;
      frame_r   <= '0;
      ch0_r     <= '0;
      ch1_r     <= '0;
    end
    else if (ready)
    begin
      ch0_r     <= channel0_sample_in;
      ch1_r     <= channel1_sample_in;
      shreg_r   <= build_frame(2'h0, channel0_sample_in,
                               channel1_sample_in);
      crc_r     <= CRC_INIT;
      bit_cnt_r <= '0;
      frame_r   <= '0;
      active_r  <= 1'b1;
    end
    else if (fall)
    begin
      sdo_r     <= active_r & out_bit; // driven low when idle
      if (active_r)
      begin
        shreg_r   <= shreg_r << 1;
        bit_cnt_r <= bit_cnt_r + 7'h01;
        if (in_payload)
          crc_r <= crc_nxt;
        if (payload_end)
          shreg_r <= {crc_nxt, 64'h0}; // checksum last
        if (frame_end)
        begin
          bit_cnt_r <= '0;
          crc_r     <= CRC_INIT;
          frame_r   <= frame_next;
          shreg_r   <= build_frame(frame_next, ch0_r, ch1_r);
          if (set_end)
            active_r <= 1'b0; // idle low until next result
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    ready_r    <= ~core_rst & ready;
    conv_rst_r <= core_rst;
  end

  assign sdo_out             = sdo_r;
  assign two_wire_active_out = two_wire_r;
  assign osr_select_out      = straps_r[1:0];
  assign ch0_gain_select_out = straps_r[4:3];
  assign boost_select_out    = straps_r[2];
  assign converter_reset_out = conv_rst_r;
  assign result_ready_out    = ready_r;

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (core_rst);

  chk_idle_output_low: assert property (
    (fall && !active_r && !ready) |=> !sdo_r)
    else $error("serial output not low while idle");
  chk_frame_count_step: assert property (
    (fall && active_r && frame_end && !set_end && !ready)
      |=> frame_r == $past(frame_next))
    else $error("frame counter did not advance");
  chk_set_end_idle: assert property (
    (fall && active_r && set_end && !ready) |=> !active_r)
    else $error("set did not end after fourth frame");
  chk_sync_const_byte: assert property (
    ready |=> shreg_r[71:64] == SYNC_CONST && frame_r == 2'h0)
    else $error("frame 0 lacks constant sync byte");
  chk_ready_timing: assert property (
    ready |-> conv_wrap && conv_st_r != CONV_START)
    else $error("result before filter settled");
  chk_osr64_no_gap: assert property (
    (ready && osr64) |-> !active_r ##1 active_r)
    else $error("ratio 64 set overlap or gap");
  chk_strap_latch: assert property (
    mode_rise |=> straps_r == $past(pins_sync[4:0]) && two_wire_r)
    else $error("straps not latched on select rise");
  chk_crc_insert: assert property (
    (fall && active_r && payload_end && !ready)
      |=> shreg_r[79:64] == $past(crc_nxt))
    else $error("checksum not placed after payload");

  cov_first_ready: cover property (ready);
  cov_set_complete: cover property (fall && active_r && set_end);
  cov_mode_entry: cover property (mode_rise);
  cov_osr64_back: cover property (ready && osr64 && two_wire_r);
endmodule

// *** test/host_clock_model.sv ***
/*
  Host model: drives the serial clock, samples data on rising edges.
  Assumes the bench steers run and hold away from the clock edges.
*/
module host_clock_model
(
  input  wire logic   run_in,
  input  wire logic   hold_high_in,
  input  wire logic   sdo_in,
  output logic        sck_out,
  output logic [79:0] rx_out,
  output int          rx_count_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    sck_out = 1'b0;
    rx_out = 80'h0;
    rx_count_out = 0;
    // odd offset keeps the link out of phase with the system clock
    #3;
    forever
    begin
      #80;
      if (hold_high_in)
        sck_out = 1'b1;
      else if (run_in)
        sck_out = ~sck_out;
      else
        sck_out = 1'b0;
    end
  end
  always @(posedge sck_out)
  begin
    rx_out <= {rx_out[78:0], sdo_in};
    rx_count_out <= rx_count_out + 1;
  end
endmodule

// *** test/two_wire_framer_tb.sv ***
/*
  Bench for the two-wire framer: straps, frame sets, watchdog.
  Assumes the host model supplies the serial clock and sampling.
*/
module two_wire_framer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import frame_out_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        sel        = 1'b0;
  logic [1:0]  osr        = 2'h0;
  logic [1:0]  gain       = 2'h0;
  logic        boost      = 1'b0;
  logic [23:0] ch0        = 24'h0;
  logic [23:0] ch1        = 24'h0;
  logic        run        = 1'b1;
  logic        hold       = 1'b0;
  logic        rst_seen   = 1'b0;
  logic        sck, sdo, active, conv_rst, ready, boost_q;
  logic [1:0]  osr_q, gain_q;
  logic [79:0] rx;
  int          rx_count, t0, bad_count, checked, cycles;

  two_wire_framer uut (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .sck_in(sck),
    .interface_select_pin_in(sel),
    .oversampling_select_lsb_in(osr[0]),
    .oversampling_select_msb_in(osr[1]), .boost_select_in(boost),
    .ch0_gain_select_lsb_in(gain[0]), .ch0_gain_select_msb_in(gain[1]),
    .channel0_sample_in(ch0), .channel1_sample_in(ch1), .sdo_out(sdo),
    .two_wire_active_out(active), .osr_select_out(osr_q),
    .ch0_gain_select_out(gain_q), .boost_select_out(boost_q),
    .converter_reset_out(conv_rst), .result_ready_out(ready));
  host_clock_model host (
    .run_in(run), .hold_high_in(hold), .sdo_in(sdo), .sck_out(sck),
    .rx_out(rx), .rx_count_out(rx_count));

  always #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in)
    if (conv_rst)
      rst_seen <= 1'b1;
  // ceiling well above the roughly 60000 cycles the run needs
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      bad_count++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check_vec(input logic [79:0] got, input logic [79:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] crc16(input logic [63:0] d, input int n);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = n - 1; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0);
    return c;
  endfunction
  function automatic logic [79:0] frame_exp(input int bits,
    input logic [1:0] cnt, input logic [4:0] cfg, input logic [23:0] a,
    input logic [23:0] b);
    logic [63:0] p;
    if (bits == 64)
    begin
      p = {16'h0, cnt, cfg, 1'b0, SYNC_CONST, a[23:8], b[23:8]};
      return {16'h0, p[47:0], crc16(p, 48)};
    end
    p = {cnt, cfg, 1'b0, SYNC_CONST, a, b};
    return {p, crc16(p, 64)};
  endfunction
  task automatic ticks(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic wait_rx(input int n);
    while (rx_count < n) @(negedge clk_sys_in);
  endtask
  // select low, long high clock, new straps, select high
  task automatic enter_mode(input logic [1:0] o, input logic [1:0] g,
    input logic b);
    sel = 1'b0;
    rst_seen = 1'b0;
    hold = 1'b1;
    ticks(450);
    hold = 1'b0;
    ticks(20);
    check_flag(rst_seen, 1'b1);
    check_flag(active, 1'b0);
    {osr, gain, boost} = {o, g, b};
    ticks(4);
    sel = 1'b1;
    while (active !== 1'b1) @(negedge clk_sys_in);
    t0 = rx_count;
  endtask
  task automatic strap_test;
    for (int i = 3; i >= 0; i--)
    begin
      enter_mode(i[1:0], ~i[1:0], i[0]);
      ticks(2);
      check_vec({75'h0, osr_q, gain_q, boost_q},
        {75'h0, i[1:0], ~i[1:0], i[0]});
      {osr, gain, boost} = ~{osr, gain, boost};
      ticks(20);
      check_vec({75'h0, osr_q, gain_q, boost_q},
        {75'h0, i[1:0], ~i[1:0], i[0]});
    end
  endtask
  task automatic frame_test(input logic [1:0] o, input int bits,
    input logic [23:0] a, input logic [23:0] b);
    logic       hi;
    int         base;
    logic [4:0] cfg;
    cfg = {o, 1'b1, 2'h2};
    {ch0, ch1} = {a, b};
    hi = 1'b0;
    enter_mode(o, 2'h2, 1'b1);
    while (ready !== 1'b1)
    begin
      hi |= (sdo !== 1'b0);
      @(negedge clk_sys_in);
    end
    check_flag(hi, 1'b0);
    base = rx_count - t0 - 14 * (64 << o);
    check_flag(base >= -3 && base <= 3, 1'b1);
    base = rx_count;
    for (int k = 0; k < 4; k++)
    begin
      wait_rx(base + bits * (k + 1));
      check_vec(bits == 64 ? {16'h0, rx[63:0]} : rx,
        frame_exp(bits, k[1:0], cfg, a, b));
    end
    wait_rx(base + bits * 4 + 8);
    check_vec({72'h0, rx[7:0]},
      (o == OSR_64) ? {72'h0, 2'h0, cfg, 1'b0} : 80'h0);
  endtask
  // low clock of any length and a short high phase must not reset
  task automatic watchdog_short;
    rst_seen = 1'b0;
    run = 1'b0;
    ticks(2000);
    run = 1'b1;
    hold = 1'b1;
    ticks(250);
    hold = 1'b0;
    ticks(40);
    check_flag(rst_seen, 1'b0);
    check_flag(active, 1'b1);
  endtask

  initial
  begin
    ticks(2);
    sys_rst_in = 1'b0;
    ticks(4);
    strap_test();
    frame_test(2'h0, 64, 24'h12ab34, 24'hfe9876);
    frame_test(2'h1, 80, 24'h5a0f3c, 24'h80017e);
    watchdog_short();
    summarize();
  end
endmodule
